// ==== msf_pkg.sv ====
// Shared constants for the memory select and flash reset block
package msf_pkg;

  // ----------------------------------------------------------------
  // Register offsets within the register space
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_PROT = 8'hC0;
  localparam logic [7:0] OFS_BOOT_PROT = 8'hC2;
  localparam logic [7:0] OFS_SPACE_MAP = 8'hC4;
  localparam logic [7:0] OFS_PAGE = 8'hE0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SECURITY = 7;
  localparam int BIT_PERIPHERAL_IO_ENABLE = 7;
  localparam int BIT_MAIN_FLASH_IN_DATA_SPACE = 4;
  localparam int BIT_BOOT_DATA = 3;
  localparam int BIT_MAIN_FLASH_IN_CODE_SPACE = 2;
  localparam int BIT_BOOT_CODE = 1;
  localparam int BIT_SRAM_CODE = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] SPACE_MAP_INIT = 8'h0C;

  // ----------------------------------------------------------------
  // Flash command sequence
  // ----------------------------------------------------------------
  localparam logic [11:0] UNLOCK1_ADDR = 12'hAAA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h554;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] RESET_CMD_DATA = 8'hF0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RECOVER_TIME_US = 25;
  localparam int RECOVER_CYCLES = (RECOVER_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int RECOVER_W = $clog2(RECOVER_CYCLES + 1);

  // Flash recovery states
  typedef enum logic [1:0] {
    MSF_READ,
    MSF_OTHER,
    MSF_RECOVER
  } msf_flash_state_t;

  // Unlock sequence states
  typedef enum logic [1:0] {
    MSF_UL_IDLE,
    MSF_UL_ONE,
    MSF_UL_TWO
  } msf_unlock_t;

endpackage : msf_pkg

// ==== msf_mem_select.sv ====
// Memory select arbitration, space map, page register and flash reset control
//
// Summary of operation
// RQ1: Main protection register bit i reads 1 when main sector i is protected.
// RQ2: Boot protection bits 3..0 show boot sector protection; bits 6..4 read zero.
// RQ3: Boot protection bit 7 reads 1 once the security flag is set.
// RQ4: Flash reset is one write, optionally after the AAh/55h unlock pair.
// RQ5: Host issues reset after ID/protect reads or after an error.
// RQ6: Reset command returns read mode at once, or after 25 us on error.
// RQ7: Reset ignored during program or bulk erase; aborts sector erase within 25 us.
// RQ8: Reset pin aborts any operation; read mode within 25 us if busy.
// RQ9: External reset pulses should last at least 25 us.
// RQ10: SRAM answers only while its select is high; select has three terms.
// RQ11: Boot sector select wins over an overlapping main sector select.
// RQ12: SRAM or register space select wins over any flash select.
// RQ13: Three priority levels; level one overrides; same level never overlaps.
// RQ14: Space map gates data reads and code fetches per memory; bit 7 PIO.
// RQ15: Space map loads its initial value at reset and stays writable.
// RQ16: Host writes 0Ch to the space map for separate spaces.
// RQ17: Host sets bits 2 and 4 for main flash in combined space.
// RQ18: Eight-bit page register at offset E0h, written and read back.
// RQ19: Page register outputs drive the decoder inputs.
// RQ20: Page register clears to zero on reset.
`timescale 1ns/1ps

module msf_mem_select #(
  parameter logic [7:0] SPACE_MAP_INIT = msf_pkg::SPACE_MAP_INIT,
  parameter logic [7:0] RESET_CMD = msf_pkg::RESET_CMD_DATA
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_reset_pin_n,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic i_code_fetch_strobe,
  input wire logic [7:0] i_main_flash_sector_select,
  input wire logic [3:0] i_boot_flash_sector_select,
  input wire logic i_sram_select,
  input wire logic i_register_space_select,
  input wire logic [7:0] i_main_protect,
  input wire logic [3:0] i_boot_protect,
  input wire logic i_security_flag,
  input wire logic i_prog_busy,
  input wire logic i_bulk_erase_busy,
  input wire logic i_sector_erase_busy,
  input wire logic i_error_status_bit,
  input wire logic i_flash_leave_read,
  output logic [7:0] o_rdata,
  output logic [7:0] o_main_flash_en,
  output logic [3:0] o_boot_flash_en,
  output logic o_sram_en,
  output logic o_register_space_en,
  output logic o_peripheral_io_enable,
  output logic [7:0] o_page_bits,
  output logic o_flash_read_mode,
  output logic o_flash_abort
);

  // ----------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;
  logic pin_level_reg;
  logic pin_level_next;
  wire pin_agree = (pin_s2_reg == pin_s3_reg);

  // Three stages; a change counts only once stages two and three agree
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_s3_reg <= 1'b1;
      pin_level_reg <= 1'b1;
    end
    else
    begin
      pin_s1_reg <= i_reset_pin_n;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_level_reg <= pin_level_next;
    end
  end

  assign pin_level_next = pin_agree ? pin_s3_reg : pin_level_reg;
  wire pin_assert = pin_level_reg & ~pin_level_next;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] page_select_reg;
  logic [7:0] memory_space_map_reg;
  logic [7:0] rdata_reg;

  // Register space decode
  wire [7:0] ofs = i_addr[7:0];
  wire reg_wr = i_register_space_select & i_wr_strobe;
  wire reg_rd = i_register_space_select & i_rd_strobe;
  wire hit_page = (ofs == msf_pkg::OFS_PAGE);
  wire hit_map = (ofs == msf_pkg::OFS_SPACE_MAP);
  wire hit_mprot = (ofs == msf_pkg::OFS_MAIN_PROT);
  wire hit_bprot = (ofs == msf_pkg::OFS_BOOT_PROT);

  // Protection views; unused boot bits read zero
  wire [7:0] main_prot_view = i_main_protect; // [RQ1]
  wire [7:0] boot_prot_view = {i_security_flag, 3'b000, i_boot_protect}; // [RQ2] [RQ3]

  // Read mux; unmapped offsets answer zero
  wire [7:0] rd_mux = hit_page ? page_select_reg : // [RQ18]
                      hit_map ? memory_space_map_reg :
                      hit_mprot ? main_prot_view :
                      hit_bprot ? boot_prot_view :
                      8'h00;

  // Page and map registers; the map keeps a host write until the next map write or reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      page_select_reg <= msf_pkg::PAGE_RST; // [RQ20]
      memory_space_map_reg <= SPACE_MAP_INIT; // [RQ15]
    end
    else
    begin
      if (reg_wr && hit_page)
        page_select_reg <= i_wdata; // [RQ18]
      if (reg_wr && hit_map)
        memory_space_map_reg <= i_wdata; // [RQ15]
    end
  end

  // Read data is captured on the read strobe and held afterwards
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      rdata_reg <= 8'h00;
    else if (reg_rd)
      rdata_reg <= rd_mux;
  end

  assign o_rdata = rdata_reg;
  assign o_page_bits = page_select_reg; // [RQ19]
  assign o_peripheral_io_enable = memory_space_map_reg[msf_pkg::BIT_PERIPHERAL_IO_ENABLE]; // [RQ14]

  // ----------------------------------------------------------------
  // Priority arbitration
  // ----------------------------------------------------------------
  // Level one: SRAM and register space; level two: boot; level three: main.
  // Same-level overlap is left to the decoder configuration.
  wire lvl1 = i_sram_select | i_register_space_select; // [RQ13]
  wire boot_any = |i_boot_flash_sector_select;
  wire [3:0] boot_pri = lvl1 ? 4'h0 : i_boot_flash_sector_select; // [RQ12]
  wire [7:0] main_pri = (lvl1 | boot_any) ? 8'h00 : // [RQ11] [RQ12]
                        i_main_flash_sector_select;

  // ----------------------------------------------------------------
  // Space map gating
  // ----------------------------------------------------------------
  // Code fetches and flash data reads each need their map bit; SRAM data reads and writes pass,
  // so flash commands work whatever the map says.
  wire [7:0] vm = memory_space_map_reg;
  wire main_ok = i_code_fetch_strobe ? vm[msf_pkg::BIT_MAIN_FLASH_IN_CODE_SPACE] : // [RQ14]
                 i_rd_strobe ? vm[msf_pkg::BIT_MAIN_FLASH_IN_DATA_SPACE] : 1'b1;
  wire boot_ok = i_code_fetch_strobe ? vm[msf_pkg::BIT_BOOT_CODE] : // [RQ14]
                 i_rd_strobe ? vm[msf_pkg::BIT_BOOT_DATA] : 1'b1;
  wire sram_ok = i_code_fetch_strobe ? vm[msf_pkg::BIT_SRAM_CODE] : 1'b1; // [RQ14]

  assign o_main_flash_en = main_ok ? main_pri : 8'h00;
  assign o_boot_flash_en = boot_ok ? boot_pri : 4'h0;
  assign o_sram_en = i_sram_select & sram_ok; // [RQ10]
  assign o_register_space_en = i_register_space_select;

  // ----------------------------------------------------------------
  // Flash command decode
  // ----------------------------------------------------------------
  msf_pkg::msf_unlock_t unlock_reg;
  msf_pkg::msf_unlock_t unlock_next;

  // A flash write is one that reaches a flash sector after arbitration
  wire flash_wr = i_wr_strobe & ((|main_pri) | (|boot_pri));
  wire [11:0] a12 = i_addr[11:0];
  wire is_ul1 = (a12 == msf_pkg::UNLOCK1_ADDR) && (i_wdata == msf_pkg::UNLOCK1_DATA);
  wire is_ul2 = (a12 == msf_pkg::UNLOCK2_ADDR) && (i_wdata == msf_pkg::UNLOCK2_DATA);
  wire is_rst = (i_wdata == RESET_CMD);
  // The reset command counts bare or after a complete unlock pair
  wire rst_cmd = flash_wr & is_rst & (unlock_reg != msf_pkg::MSF_UL_ONE); // [RQ4]

  // Unlock tracker; any other write drops back to idle
  always_comb
  begin
    unlock_next = unlock_reg;
    if (flash_wr)
    begin
      case (unlock_reg)
        msf_pkg::MSF_UL_IDLE:
          unlock_next = is_ul1 ? msf_pkg::MSF_UL_ONE : msf_pkg::MSF_UL_IDLE;
        msf_pkg::MSF_UL_ONE:
          unlock_next = is_ul2 ? msf_pkg::MSF_UL_TWO : msf_pkg::MSF_UL_IDLE;
        msf_pkg::MSF_UL_TWO:
          unlock_next = msf_pkg::MSF_UL_IDLE;
        default:
          unlock_next = msf_pkg::MSF_UL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      unlock_reg <= msf_pkg::MSF_UL_IDLE;
    else
      unlock_reg <= unlock_next;
  end

  // ----------------------------------------------------------------
  // Flash reset state machine
  // ----------------------------------------------------------------
  localparam int RW = msf_pkg::RECOVER_W;
  localparam logic [RW-1:0] RECOVER_LAST = RW'(msf_pkg::RECOVER_CYCLES - 1);

  msf_pkg::msf_flash_state_t fstate_reg;
  msf_pkg::msf_flash_state_t fstate_next;
  logic [RW-1:0] rec_cnt_reg;
  logic [RW-1:0] rec_cnt_next;
  logic abort_reg;
  logic abort_next;

  wire busy_locked = i_prog_busy | i_bulk_erase_busy;
  wire any_busy = busy_locked | i_sector_erase_busy;
  // Command accepted only when no program or bulk erase is running
  wire cmd_ok = rst_cmd & ~busy_locked; // [RQ7]
  wire cmd_slow = cmd_ok & (i_error_status_bit | i_sector_erase_busy); // [RQ6] [RQ7]
  wire pin_slow = pin_assert & any_busy; // [RQ8]

  // Next-state logic; the pin has priority over a command in the same cycle
  always_comb
  begin
    fstate_next = fstate_reg;
    rec_cnt_next = rec_cnt_reg;
    abort_next = 1'b0;
    if (pin_assert)
    begin
      abort_next = any_busy; // [RQ8]
      rec_cnt_next = '0;
      fstate_next = pin_slow ? msf_pkg::MSF_RECOVER : msf_pkg::MSF_READ; // [RQ8]
    end
    else
    begin
      case (fstate_reg)
        msf_pkg::MSF_READ:
        begin
          if (i_flash_leave_read)
            fstate_next = msf_pkg::MSF_OTHER;
        end
        msf_pkg::MSF_OTHER:
        begin
          if (cmd_ok)
          begin
            abort_next = i_sector_erase_busy; // [RQ7]
            rec_cnt_next = '0;
            fstate_next = cmd_slow ? msf_pkg::MSF_RECOVER : // [RQ6]
                          msf_pkg::MSF_READ;
          end
        end
        msf_pkg::MSF_RECOVER:
        begin
          // Fixed 25 us wait, then read mode
          if (rec_cnt_reg == RECOVER_LAST)
            fstate_next = msf_pkg::MSF_READ; // [RQ6] [RQ7] [RQ8]
          else
            rec_cnt_next = rec_cnt_reg + 1'b1;
        end
        default:
          fstate_next = msf_pkg::MSF_READ;
      endcase
    end
  end

  // Recovery state; starts in read mode after reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      fstate_reg <= msf_pkg::MSF_READ;
      rec_cnt_reg <= '0;
      abort_reg <= 1'b0;
    end
    else
    begin
      fstate_reg <= fstate_next;
      rec_cnt_reg <= rec_cnt_next;
      abort_reg <= abort_next;
    end
  end

  assign o_flash_read_mode = (fstate_reg == msf_pkg::MSF_READ);
  assign o_flash_abort = abort_reg;

endmodule : msf_mem_select

// ==== msf_mem_select_checker.sv ====
// Concurrent checks on the ports of the memory select block
`timescale 1ns/1ps
module msf_mem_select_checker (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [7:0] i_main_flash_sector_select,
  input wire logic [3:0] i_boot_flash_sector_select,
  input wire logic i_sram_select,
  input wire logic i_register_space_select,
  input wire logic [7:0] i_main_protect,
  input wire logic [3:0] i_boot_protect,
  input wire logic i_security_flag,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_main_flash_en,
  input wire logic [3:0] o_boot_flash_en,
  input wire logic o_sram_en,
  input wire logic o_peripheral_io_enable,
  input wire logic [7:0] o_page_bits,
  input wire logic o_flash_read_mode,
  input wire logic o_flash_abort
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  // Register cycles decoded once so every register property sees the same cause
  logic rd_c;
  logic wr_c;
  assign rd_c = i_register_space_select && i_rd_strobe;
  assign wr_c = i_register_space_select && i_wr_strobe;
  a_sram_wins: assert property ((i_sram_select || i_register_space_select) |->
    (o_main_flash_en == 8'h00) && (o_boot_flash_en == 4'h0)) else $error("flash under sram");
  a_boot_wins: assert property ((|i_boot_flash_sector_select) |->
    o_main_flash_en == 8'h00) else $error("main flash beat boot flash");
  a_sram_gate: assert property (!i_sram_select |-> !o_sram_en)
    else $error("sram enabled without select");
  a_page_clear: assert property ($fell(i_reset) |-> o_page_bits == 8'h00)
    else $error("page not cleared");
  a_page_load: assert property (wr_c && i_addr[7:0] == msf_pkg::OFS_PAGE |=>
    o_page_bits == $past(i_wdata)) else $error("page write lost");
  a_page_echo: assert property (rd_c && i_addr[7:0] == msf_pkg::OFS_PAGE |=>
    o_rdata == $past(o_page_bits)) else $error("page read wrong");
  a_main_prot: assert property (rd_c && i_addr[7:0] == msf_pkg::OFS_MAIN_PROT |=>
    o_rdata == $past(i_main_protect)) else $error("main protect read wrong");
  a_boot_prot: assert property (rd_c && i_addr[7:0] == msf_pkg::OFS_BOOT_PROT |=>
    o_rdata == {$past(i_security_flag), 3'h0, $past(i_boot_protect)})
    else $error("boot protect read wrong");
  a_pio_load: assert property (wr_c && i_addr[7:0] == msf_pkg::OFS_SPACE_MAP |=>
    o_peripheral_io_enable == $past(i_wdata[7])) else $error("map bit 7 lost");
  a_abort_recover: assert property (o_flash_abort |=>
    (!o_flash_abort && !o_flash_read_mode) [*8]) else $error("abort pulse or recovery wrong");
  c_page: cover property (wr_c && i_addr[7:0] == msf_pkg::OFS_PAGE);
  c_abort: cover property (o_flash_abort);
  c_overlap: cover property ((|i_boot_flash_sector_select) && (|i_main_flash_sector_select));
endmodule : msf_mem_select_checker

bind msf_mem_select msf_mem_select_checker msf_mem_select_checker_inst (.i_ref_clk, .i_reset,
  .i_addr, .i_wdata, .i_wr_strobe, .i_rd_strobe, .i_main_flash_sector_select,
  .i_boot_flash_sector_select, .i_sram_select, .i_register_space_select, .i_main_protect,
  .i_boot_protect, .i_security_flag, .o_rdata, .o_main_flash_en, .o_boot_flash_en, .o_sram_en,
  .o_peripheral_io_enable, .o_page_bits, .o_flash_read_mode, .o_flash_abort);

// ==== msf_host_model.sv ====
// Host bus model that issues register, flash and fetch cycles
`timescale 1ns/1ps
module msf_host_model (
  input wire logic i_ref_clk,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr_strobe,
  output logic o_rd_strobe,
  output logic o_code_fetch_strobe,
  output logic o_register_space_select
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus from time zero
  initial
  begin
    o_addr = 16'h0000;
    o_wdata = 8'h00;
    {o_wr_strobe, o_rd_strobe, o_code_fetch_strobe, o_register_space_select} = 4'h0;
  end
  // Control code is write, read, fetch, register select; one write is one command
  task automatic drive(input logic [15:0] a, input logic [7:0] d, input logic [3:0] c);
    @(posedge i_ref_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    {o_wr_strobe, o_rd_strobe, o_code_fetch_strobe, o_register_space_select} = c;
  endtask : drive
  // Released strobes drop to zero; address and data show the inverse so a stale value can never pass
  task automatic rel;
    @(posedge i_ref_clk);
    #1;
    {o_wr_strobe, o_rd_strobe, o_code_fetch_strobe, o_register_space_select} = 4'h0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : rel
endmodule : msf_host_model

// ==== msf_mem_select_tb.sv ====
// Self-checking bench for the memory select block
`timescale 1ns/1ps
module msf_mem_select_tb;
  // ----------------------------------------------------------------
  // Signals, model state and helpers
  // ----------------------------------------------------------------
  logic i_ref_clk, i_reset, i_reset_pin_n, i_wr_strobe, i_rd_strobe, i_code_fetch_strobe;
  logic i_sram_select, i_register_space_select, i_security_flag, i_prog_busy;
  logic i_bulk_erase_busy, i_sector_erase_busy, i_error_status_bit, i_flash_leave_read;
  logic o_sram_en, o_register_space_en, o_peripheral_io_enable, o_flash_read_mode, o_flash_abort;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, i_main_flash_sector_select, i_main_protect, o_rdata, o_main_flash_en;
  logic [7:0] o_page_bits;
  logic [3:0] i_boot_flash_sector_select, i_boot_protect, o_boot_flash_en;
  logic ab;
  int err_count, compares, page_m, map_m, r, n, seed;
  int maps[4] = '{'h0C, 'h14, 'h8B, 'h00};
  msf_mem_select msf_mem_select_inst (.*);
  msf_host_model msf_host_model_inst (.i_ref_clk, .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr_strobe(i_wr_strobe), .o_rd_strobe(i_rd_strobe),
    .o_code_fetch_strobe(i_code_fetch_strobe), .o_register_space_select(i_register_space_select));
  // Free-running clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
    msf_host_model_inst.drive(a, 8'h00, 4'h5);
    chk(o_register_space_en, 1'b1);
    msf_host_model_inst.rel();
    chk(o_rdata, exp);
  endtask : rreg
  task automatic fwr(input logic [15:0] a, input logic [7:0] d);
    msf_host_model_inst.drive(a, d, {3'h4, a[7:0] == 8'hE0 || a[7:0] == 8'hC4});
    msf_host_model_inst.rel();
  endtask : fwr
  // Flash core leaves read mode for a pulse, as after an ID read
  task automatic leave;
    @(posedge i_ref_clk);
    #1 i_flash_leave_read = 1'b1;
    @(posedge i_ref_clk);
    #1 i_flash_leave_read = 1'b0;
    chk(o_flash_read_mode, 1'b0);
  endtask : leave
  // Bounded wait for read mode, noting any abort pulse on the way
  task automatic settle;
    n = 0;
    ab = o_flash_abort;
    while (o_flash_read_mode !== 1'b1 && n < 1100)
    begin
      @(posedge i_ref_clk);
      #1 ab = ab | o_flash_abort;
      n++;
    end
  endtask : settle
  // Watchdog sized well above the few thousand cycles of the sequence
  initial
  begin
    #(25 * 12000);
    err_count++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {i_main_flash_sector_select, i_boot_flash_sector_select, i_sram_select} = 13'h0;
    {i_main_protect, i_boot_protect, i_security_flag, i_prog_busy} = 14'h0;
    {i_bulk_erase_busy, i_sector_erase_busy, i_error_status_bit, i_flash_leave_read} = 4'h0;
    i_reset_pin_n = 1'b1;
    i_reset = 1'b1;
    seed = 70;
    repeat (3) @(posedge i_ref_clk);
    #1 i_reset = 1'b0;
    rreg(16'h00E0, 8'h00);
    rreg(16'h00C4, msf_pkg::SPACE_MAP_INIT);
    rreg(16'h00F7, 8'h00);
    repeat (8)
    begin
      page_m = $random(seed) & 255;
      fwr(16'h00E0, page_m[7:0]);
      chk(o_page_bits, page_m[7:0]);
      rreg(16'h00E0, page_m[7:0]);
    end
    {i_main_protect, i_boot_protect, i_security_flag} = 13'($random(seed));
    msf_host_model_inst.drive(16'h00C0, 8'h5A, 4'h9);
    msf_host_model_inst.rel();
    rreg(16'h00C0, i_main_protect);
    rreg(16'h00C2, {i_security_flag, 3'h0, i_boot_protect});
    $display("test registers done");
    // Map settings crossed with random selects; one boot sector at most per address
    foreach (maps[k])
    begin
      map_m = maps[k];
      fwr(16'h00C4, map_m[7:0]);
      chk(o_peripheral_io_enable, map_m[7]);
      repeat (12)
      begin
        r = $random(seed);
        i_main_flash_sector_select = 8'h01 << r[10:8];
        i_boot_flash_sector_select = r[3] ? 4'h1 << r[5:4] : 4'h0;
        i_sram_select = r[6];
        msf_host_model_inst.drive(16'h8000, 8'h00, r[7] ? 4'h2 : 4'h4);
        #1 chk(o_sram_en, r[6] & (r[7] ? map_m[0] : 1'b1));
        chk(o_boot_flash_en, (r[6] ? 4'h0 : i_boot_flash_sector_select) &
          {4{r[7] ? map_m[1] : map_m[3]}});
        chk(o_main_flash_en, (r[6] | r[3] ? 8'h00 : i_main_flash_sector_select) &
          {8{r[7] ? map_m[2] : map_m[4]}});
        msf_host_model_inst.rel();
      end
    end
    $display("test selects done");
    {i_main_flash_sector_select, i_boot_flash_sector_select, i_sram_select} = 13'h100;
    leave();
    fwr(16'h0000, 8'hF0);
    chk(o_flash_read_mode, 1'b1);
    leave();
    fwr(16'h0AAA, 8'hAA);
    fwr(16'h0554, 8'h55);
    fwr(16'h0000, 8'hF0);
    chk(o_flash_read_mode, 1'b1);
    leave();
    i_prog_busy = 1'b1;
    fwr(16'h0000, 8'hF0);
    chk(o_flash_read_mode, 1'b0);
    {i_prog_busy, i_bulk_erase_busy} = 2'h1;
    fwr(16'h0000, 8'hF0);
    chk(o_flash_read_mode, 1'b0);
    {i_bulk_erase_busy, i_error_status_bit} = 2'h1;
    fwr(16'h0000, 8'hF0);
    settle();
    // Read mode returns 25 us after the edge that takes the command
    chk(16'(n), 16'(msf_pkg::RECOVER_CYCLES));
    {i_error_status_bit, i_sector_erase_busy} = 2'h1;
    leave();
    fwr(16'h0000, 8'hF0);
    settle();
    chk(16'(ab), 16'h0001);
    chk(16'(n), 16'(msf_pkg::RECOVER_CYCLES));
    leave();
    // Pin held low through the whole recovery, so the pulse lasts over 25 us
    #1 i_reset_pin_n = 1'b0;
    settle();
    #1 i_reset_pin_n = 1'b1;
    chk({ab, o_flash_read_mode}, 2'h3);
    $display("test flash reset done");
    summarize();
  end
endmodule : msf_mem_select_tb
